/* common/rdc_pkg.sv */
/*
 * Constants for the reader direct command unit: APB register map, field
 * positions, reset values, command codes and timing counts.
 * Assumes a 100 MHz system clock and a 32-bit APB master.
 */
package rdc_pkg;
    // Register byte addresses
    localparam logic [7:0] RDC_A_CMD = 8'h00;
    localparam logic [7:0] RDC_A_CFG = 8'h04;
    localparam logic [7:0] RDC_A_TXDLY = 8'h08;
    localparam logic [7:0] RDC_A_RXDLY = 8'h0c;
    localparam logic [7:0] RDC_A_TXLEN = 8'h10;
    localparam logic [7:0] RDC_A_FIFO = 8'h14;
    localparam logic [7:0] RDC_A_ADC = 8'h18;
    localparam logic [7:0] RDC_A_STAT = 8'h1c;
    localparam logic [7:0] RDC_A_EVT = 8'h20;
    localparam logic [7:0] RDC_A_RN16 = 8'h24;
    // Config field positions
    localparam int RDC_CFG_MSEL_LSB = 0;
    localparam int RDC_CFG_MSEL_W = 3;
    localparam logic [7:0] RDC_CFG_RST = 8'h00;
    localparam logic [7:0] RDC_DLY_RST = 8'h00;
    // Command codes
    localparam logic [7:0] RDC_C_IDLE = 8'h80;
    localparam logic [7:0] RDC_C_INIT = 8'h83;
    localparam logic [7:0] RDC_C_MAIN = 8'h84;
    localparam logic [7:0] RDC_C_AUX = 8'h85;
    localparam logic [7:0] RDC_C_ADC = 8'h87;
    localparam logic [7:0] RDC_C_FRST = 8'h8f;
    localparam logic [7:0] RDC_C_TXC = 8'h90;
    localparam logic [7:0] RDC_C_TXH = 8'h91;
    localparam logic [7:0] RDC_C_TXN = 8'h92;
    localparam logic [7:0] RDC_C_DTXN = 8'h93;
    localparam logic [7:0] RDC_C_DTXC = 8'h94;
    localparam logic [7:0] RDC_C_BLK = 8'h96;
    localparam logic [7:0] RDC_C_ENRX = 8'h97;
    localparam logic [7:0] RDC_C_QRY = 8'h98;
    localparam logic [7:0] RDC_C_QLAST = 8'h9c;
    localparam logic [7:0] RDC_C_ACK = 8'h9d;
    // CRC selection encodings
    localparam logic [1:0] RDC_CRC_NONE = 2'h0;
    localparam logic [1:0] RDC_CRC_16 = 2'h1;
    localparam logic [1:0] RDC_CRC_5 = 2'h2;
    // Query receive length in bits
    localparam logic [9:0] RDC_QRY_RXLEN = 10'h010;
    // Start threshold in payload bytes
    localparam logic [11:0] RDC_TX_START = 12'h003;
    // Delay tick: one wait unit in ns, and its cycle count at 100 MHz
    localparam int RDC_CLK_NS = 10;
    localparam int RDC_TICK_NS = 1000;
    localparam int RDC_TICK_CYC = (RDC_TICK_NS + RDC_CLK_NS - 1) / RDC_CLK_NS;
    // ADC conversion time in ns and cycles
    localparam int RDC_ADC_NS = 500;
    localparam int RDC_ADC_CYC = (RDC_ADC_NS + RDC_CLK_NS - 1) / RDC_CLK_NS;
    // Sequencer states
    typedef enum logic [3:0] {
        RDC_S_IDLE = 4'b0001,
        RDC_S_WAIT = 4'b0010,
        RDC_S_SEND = 4'b0100,
        RDC_S_RXW = 4'b1000
    } rdc_state_e;
endpackage

/* design/rdc_delay_timer.sv */
/*
 * Loadable down counter in units of one wait tick.
 * Assumes a synchronous start pulse; done pulses once when it elapses.
 */
`timescale 1ns/1ps
module rdc_delay_timer
    import rdc_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Control
    input wire logic i_start,
    input wire logic [7:0] i_units,
    // Status
    output logic o_running,
    output logic o_done
);
    logic [7:0] units;
    logic [7:0] next_units;
    logic [15:0] tick;
    logic [15:0] next_tick;
    logic run;
    logic next_run;
    logic done;
    logic next_done;

    // Restart on every start pulse so the count runs from the latest event
    always_comb begin
        next_units = units;
        next_tick = tick;
        next_run = run;
        next_done = 1'b0;
        if (i_start) begin
            next_units = i_units;
            next_tick = 16'(RDC_TICK_CYC - 1);
            next_run = (i_units != 8'h00);
            next_done = (i_units == 8'h00);
        end else if (run) begin
            if (tick == 16'h0000) begin
                next_tick = 16'(RDC_TICK_CYC - 1);
                next_units = units - 8'h01;
                if (units == 8'h01) begin
                    next_run = 1'b0;
                    next_done = 1'b1;
                end
            end else begin
                next_tick = tick - 16'h0001;
            end
        end
    end

    // State registers
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            units <= 8'h00;
            tick <= 16'h0000;
            run <= 1'b0;
            done <= 1'b0;
        end else begin
            units <= next_units;
            tick <= next_tick;
            run <= next_run;
            done <= next_done;
        end
    end

    assign o_running = run;
    assign o_done = done;
endmodule

/* design/rdc_adc_seq.sv */
/*
 * Single-shot conversion sequencer for the 8-bit converter.
 * Assumes the analog sample inputs are synchronous and stable.
 */
`timescale 1ns/1ps
module rdc_adc_seq
    import rdc_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_clear,
    // Control
    input wire logic i_trigger,
    input wire logic [2:0] i_source,
    // Sample sources
    input wire logic [7:0] i_mix_i,
    input wire logic [7:0] i_mix_q,
    input wire logic [7:0] i_pin,
    input wire logic [7:0] i_test,
    // Result
    output logic o_busy,
    output logic o_done,
    output logic [7:0] o_result
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic busy;
    logic next_busy;
    logic done;
    logic next_done;
    logic [7:0] result;
    logic [7:0] next_result;
    logic [2:0] src;
    logic [2:0] next_src;
    logic [7:0] sample;

    // Source mux: two mixers, external pin, the rest test input
    always_comb begin
        case (src)
            3'h1: sample = i_mix_i;
            3'h2: sample = i_mix_q;
            3'h3: sample = i_pin;
            default: sample = i_test;
        endcase
    end

    // Source latched at trigger so a late change cannot corrupt the result
    always_comb begin
        next_cnt = cnt;
        next_busy = busy;
        next_done = 1'b0;
        next_result = result;
        next_src = src;
        if (i_clear) begin
            next_cnt = 8'h00;
            next_busy = 1'b0;
            next_result = 8'h00;
        end else if (i_trigger && !busy) begin
            next_src = i_source;
            next_cnt = 8'(RDC_ADC_CYC - 1);
            next_busy = 1'b1;
        end else if (busy) begin
            if (cnt == 8'h00) begin
                next_busy = 1'b0;
                next_done = 1'b1;
                next_result = sample;
            end else begin
                next_cnt = cnt - 8'h01;
            end
        end
    end

    // State registers
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
            result <= 8'h00;
            src <= 3'h0;
        end else begin
            cnt <= next_cnt;
            busy <= next_busy;
            done <= next_done;
            result <= next_result;
            src <= next_src;
        end
    end

    assign o_busy = busy;
    assign o_done = done;
    assign o_result = result;
endmodule

/* design/rdc_top.sv */
/*
 * Direct command unit: APB slave taking command bytes and dispatching them
 * to frequency select, converter, FIFO reset, transmit and receiver control.
 * Assumes the transmitter, receiver and FIFO sit outside and exchange
 * one-cycle synchronous pulses with this block.
 */
`timescale 1ns/1ps
module rdc_top
    import rdc_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Converter sources
    input wire logic [7:0] i_mix_i,
    input wire logic [7:0] i_mix_q,
    input wire logic [7:0] i_adc_pin,
    input wire logic [7:0] i_adc_test,
    // Transmitter and receiver events
    input wire logic i_tx_done,
    input wire logic i_rx_end,
    input wire logic i_rx_rn16_vld,
    input wire logic [15:0] i_rx_rn16,
    // Synthesizer and datapath control
    output logic o_pll_aux,
    output logic o_tx_start,
    output logic [1:0] o_tx_crc,
    output logic o_tx_ack_rn16,
    output logic [15:0] o_tx_rn16,
    output logic o_rx_header,
    output logic o_rx_nocrc,
    output logic o_rx_len_force,
    output logic [9:0] o_rx_len,
    output logic o_rx_hold,
    output logic o_fifo_clear,
    output logic o_soft_init
);
    // Register file
    logic [7:0] cfg, next_cfg;
    logic [7:0] txdly, next_txdly;
    logic [7:0] rxdly, next_rxdly;
    logic [11:0] txlen, next_txlen;
    logic [11:0] fcnt, next_fcnt;
    logic [7:0] errloc, next_errloc;
    logic [2:0] evt, next_evt;
    logic [15:0] rn16, next_rn16;
    // Control state
    rdc_state_e state, next_state;
    logic aux, next_aux;
    logic blocked, next_blocked;
    logic start, next_start;
    logic [1:0] crc, next_crc;
    logic ackr, next_ackr;
    logic hdr, next_hdr;
    logic nocrc, next_nocrc;
    logic qforce, next_qforce;
    logic fclr, next_fclr;
    logic sinit, next_sinit;
    logic delayed, next_delayed;
    logic [31:0] prdata, next_prdata;
    logic pready, next_pready;
    logic pslverr, next_pslverr;
    // Decode helpers
    logic acc, wr, cmd_wr;
    logic [7:0] cmd;
    logic adc_trig, adc_busy, adc_done;
    logic [7:0] adc_res;
    logic tx_tmr_start, tx_tmr_run, tx_tmr_done;
    logic rx_tmr_start, rx_tmr_run, rx_tmr_done;

    // Command byte test: bit 7 marks a command
    function automatic logic is_cmd(input logic [7:0] b);
        return b[7];
    endfunction

    // Query family range check
    function automatic logic is_query(input logic [7:0] b);
        return (b >= RDC_C_QRY) && (b <= RDC_C_QLAST);
    endfunction

    // Two-cycle access phase: acc marks only the first access cycle; pready answers one cycle later
    assign acc = i_psel && i_penable && !pready;
    assign wr = acc && i_pwrite;
    assign cmd = i_pwdata[7:0];
    assign cmd_wr = wr && (i_paddr == RDC_A_CMD) && is_cmd(cmd);
    assign adc_trig = cmd_wr && (cmd == RDC_C_ADC);
    // Transmit delay timer re-armed at each reception end, never by the command; receive timer at transmit done
    assign tx_tmr_start = i_rx_end;
    assign rx_tmr_start = i_tx_done && (rxdly != 8'h00);

    rdc_adc_seq u_adc (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_clear(sinit),
        .i_trigger(adc_trig),
        .i_source(cfg[RDC_CFG_MSEL_LSB +: RDC_CFG_MSEL_W]),
        .i_mix_i(i_mix_i),
        .i_mix_q(i_mix_q),
        .i_pin(i_adc_pin),
        .i_test(i_adc_test),
        .o_busy(adc_busy),
        .o_done(adc_done),
        .o_result(adc_res)
    );

    rdc_delay_timer u_txtmr (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_start(tx_tmr_start || sinit), // soft init leaves no delay counting
        .i_units(sinit ? RDC_DLY_RST : txdly),
        .o_running(tx_tmr_run),
        .o_done(tx_tmr_done)
    );

    rdc_delay_timer u_rxtmr (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_start(rx_tmr_start || sinit),
        .i_units(sinit ? RDC_DLY_RST : rxdly),
        .o_running(rx_tmr_run),
        .o_done(rx_tmr_done)
    );

    // Register writes, command dispatch and status events
    always_comb begin
        next_cfg = cfg;
        next_txdly = txdly;
        next_rxdly = rxdly;
        next_txlen = txlen;
        next_fcnt = fcnt;
        next_errloc = errloc;
        next_evt = evt;
        next_rn16 = rn16;
        next_aux = aux;
        next_crc = crc;
        next_ackr = ackr;
        next_hdr = hdr;
        next_nocrc = nocrc;
        next_qforce = qforce;
        next_delayed = delayed;
        next_fclr = 1'b0;
        next_sinit = 1'b0;
        next_blocked = blocked;
        if (wr) begin
            case (i_paddr)
                RDC_A_CFG: next_cfg = i_pwdata[7:0];
                RDC_A_TXDLY: next_txdly = i_pwdata[7:0];
                RDC_A_RXDLY: next_rxdly = i_pwdata[7:0];
                RDC_A_TXLEN: next_txlen = i_pwdata[11:0];
                RDC_A_FIFO: next_fcnt = fcnt + 12'h001;
                default: ;
            endcase
        end
        if (wr && (i_paddr == RDC_A_EVT)) begin
            next_errloc = i_pwdata[15:8];
        end
        // Hardware events win over status clears in the same cycle, but lose to the FIFO reset command
        if (wr && (i_paddr == RDC_A_STAT)) begin
            next_evt = evt & ~i_pwdata[2:0];
        end
        if (adc_done) begin
            next_evt[0] = 1'b1;
        end
        if (i_tx_done) begin
            next_evt[1] = 1'b1;
        end
        if (i_rx_end) begin
            next_evt[2] = 1'b1;
        end
        if (i_rx_rn16_vld && qforce) begin
            next_rn16 = i_rx_rn16;
        end
        if (i_tx_done) begin
            next_txlen = 12'h000;
            next_fcnt = 12'h000;
            next_blocked = 1'b0;
        end
        if (rx_tmr_start) begin
            next_blocked = 1'b1;
        end
        if (rx_tmr_done) begin
            next_blocked = 1'b0;
        end
        if (cmd_wr) begin
            case (cmd)
                RDC_C_IDLE: ;
                RDC_C_INIT: next_sinit = 1'b1;
                RDC_C_MAIN: next_aux = 1'b0;
                RDC_C_AUX: next_aux = 1'b1;
                RDC_C_FRST: begin
                    next_fclr = 1'b1;
                    next_fcnt = 12'h000;
                    next_evt = 3'h0;
                    next_errloc = 8'h00;
                end
                RDC_C_TXC, RDC_C_TXH, RDC_C_TXN, RDC_C_DTXN, RDC_C_DTXC: begin
                    next_crc = (cmd == RDC_C_TXN || cmd == RDC_C_DTXN)
                        ? RDC_CRC_NONE : RDC_CRC_16;
                    next_hdr = (cmd == RDC_C_TXH);
                    next_delayed = (cmd == RDC_C_DTXN || cmd == RDC_C_DTXC);
                    next_nocrc = 1'b0;
                    next_qforce = 1'b0;
                    next_ackr = 1'b0;
                end
                RDC_C_BLK: next_blocked = 1'b1;
                RDC_C_ENRX: next_blocked = 1'b0;
                RDC_C_ACK: begin
                    next_ackr = 1'b1;
                    next_crc = RDC_CRC_NONE;
                    next_delayed = 1'b0;
                    next_hdr = 1'b0;
                end
                default: begin
                    if (is_query(cmd)) begin
                        next_crc = (cmd == RDC_C_QRY) ? RDC_CRC_5 : RDC_CRC_NONE;
                        next_nocrc = 1'b1;
                        next_qforce = 1'b1;
                        next_hdr = 1'b0;
                        next_ackr = 1'b0;
                        next_delayed = 1'b0;
                    end
                end
            endcase
        end
    end

    // Transmit sequencer
    always_comb begin
        next_state = state;
        next_start = 1'b0;
        case (state)
            RDC_S_IDLE: begin
                if (cmd_wr && ((cmd >= RDC_C_TXC && cmd <= RDC_C_DTXC && cmd != 8'h95)
                        || is_query(cmd) || cmd == RDC_C_ACK)) begin
                    next_state = RDC_S_WAIT;
                end
            end
            RDC_S_WAIT: begin
                // Payload gate: third byte, or all of a shorter message; zero length waits, queries and ACK pass at once
                if ((fcnt >= RDC_TX_START) || ((txlen != 12'h000) && (fcnt >= txlen))
                        || !(crc == RDC_CRC_16 || !qforce && !ackr)) begin
                    if (!delayed) begin
                        next_start = 1'b1;
                        next_state = RDC_S_SEND;
                    end else begin
                        next_state = RDC_S_RXW;
                    end
                end
            end
            RDC_S_RXW: begin
                // Waits out the reception-end delay; one already elapsed cannot hang it
                if (tx_tmr_done || !tx_tmr_run) begin
                    next_start = 1'b1;
                    next_state = RDC_S_SEND;
                end
            end
            RDC_S_SEND: begin
                if (i_tx_done) begin
                    next_state = RDC_S_IDLE;
                end
            end
            default: next_state = RDC_S_IDLE;
        endcase
        if (sinit) begin
            next_state = RDC_S_IDLE;
        end
    end

    // APB read mux and answer; unmapped reads return zero with an error
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_pready = acc;
        next_pslverr = 1'b0;
        if (acc) begin
            case (i_paddr)
                RDC_A_CMD: next_prdata = 32'h0000_0000;
                RDC_A_CFG: next_prdata = {24'h00_0000, cfg};
                RDC_A_TXDLY: next_prdata = {24'h00_0000, txdly};
                RDC_A_RXDLY: next_prdata = {24'h00_0000, rxdly};
                RDC_A_TXLEN: next_prdata = {20'h0_0000, txlen};
                RDC_A_FIFO: next_prdata = {20'h0_0000, fcnt};
                RDC_A_ADC: next_prdata = {23'h00_0000, adc_busy, adc_res};
                RDC_A_STAT: next_prdata = {22'h00_0000, tx_tmr_run | rx_tmr_run,
                    blocked, aux, state, evt};
                RDC_A_EVT: next_prdata = {16'h0000, errloc, 8'h00};
                RDC_A_RN16: next_prdata = {16'h0000, rn16};
                default: next_pslverr = 1'b1;
            endcase
        end
    end

    // All state; soft init reloads power-on defaults except the APB answer, and pulses the FIFO clear
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg <= RDC_CFG_RST;
            txdly <= RDC_DLY_RST;
            rxdly <= RDC_DLY_RST;
            txlen <= 12'h000;
            fcnt <= 12'h000;
            errloc <= 8'h00;
            evt <= 3'h0;
            rn16 <= 16'h0000;
            aux <= 1'b0;
            blocked <= 1'b0;
            crc <= RDC_CRC_NONE;
            ackr <= 1'b0;
            hdr <= 1'b0;
            nocrc <= 1'b0;
            qforce <= 1'b0;
            delayed <= 1'b0;
            fclr <= 1'b0;
            sinit <= 1'b0;
            state <= RDC_S_IDLE;
            start <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (sinit) begin
            cfg <= RDC_CFG_RST;
            txdly <= RDC_DLY_RST;
            rxdly <= RDC_DLY_RST;
            txlen <= 12'h000;
            fcnt <= 12'h000;
            errloc <= 8'h00;
            evt <= 3'h0;
            rn16 <= 16'h0000;
            aux <= 1'b0;
            blocked <= 1'b0;
            crc <= RDC_CRC_NONE;
            ackr <= 1'b0;
            hdr <= 1'b0;
            nocrc <= 1'b0;
            qforce <= 1'b0;
            delayed <= 1'b0;
            fclr <= 1'b1;
            sinit <= 1'b0;
            state <= RDC_S_IDLE;
            start <= 1'b0;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end else begin
            cfg <= next_cfg;
            txdly <= next_txdly;
            rxdly <= next_rxdly;
            txlen <= next_txlen;
            fcnt <= next_fcnt;
            errloc <= next_errloc;
            evt <= next_evt;
            rn16 <= next_rn16;
            aux <= next_aux;
            blocked <= next_blocked;
            crc <= next_crc;
            ackr <= next_ackr;
            hdr <= next_hdr;
            nocrc <= next_nocrc;
            qforce <= next_qforce;
            delayed <= next_delayed;
            fclr <= next_fclr;
            sinit <= next_sinit;
            state <= next_state;
            start <= next_start;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Outputs come straight from flip-flops
    assign o_prdata = prdata;
    assign o_pready = pready;
    assign o_pslverr = pslverr;
    assign o_pll_aux = aux;
    assign o_tx_start = start;
    assign o_tx_crc = crc;
    assign o_tx_ack_rn16 = ackr;
    assign o_tx_rn16 = rn16;
    assign o_rx_header = hdr;
    assign o_rx_nocrc = nocrc;
    assign o_rx_len_force = qforce;
    assign o_rx_len = qforce ? RDC_QRY_RXLEN : 10'h000;
    assign o_rx_hold = blocked;
    assign o_fifo_clear = fclr;
    assign o_soft_init = sinit;
endmodule

/* dv/rdc_top_checker.sv */
/* Port assertions for the command unit.
   Bound into rdc_top; sees only its ports. */
`timescale 1ns/1ps
module rdc_top_checker
    import rdc_pkg::*;
(
    // Clock, reset and APB
    input wire logic i_clock, i_rst_n, i_psel, i_penable, i_pwrite, o_pready,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    // Control outputs
    input wire logic o_pll_aux, o_tx_start, o_rx_hold, o_fifo_clear,
    input wire logic o_soft_init, o_rx_len_force,
    input wire logic [9:0] o_rx_len
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    logic cw;
    logic [7:0] cb;
    // Command byte taken at this edge
    assign cw = i_psel & i_penable & i_pwrite & !o_pready & (i_paddr == RDC_A_CMD);
    assign cb = i_pwdata[7:0];
    a_aux_sel: assert property (cw && cb == 8'h85 |-> ##[1:3] o_pll_aux)
        else $error("aux not selected");
    a_main_sel: assert property (cw && cb == 8'h84 |-> ##[1:3] !o_pll_aux)
        else $error("main not selected");
    a_hold_set: assert property (cw && cb == 8'h96 |-> ##[1:3] o_rx_hold)
        else $error("rx not held");
    a_rx_release: assert property (cw && cb == 8'h97 |-> ##[1:3] !o_rx_hold)
        else $error("rx not released");
    a_fifo_clr: assert property (cw && cb == 8'h8f |-> ##[1:3] o_fifo_clear)
        else $error("no fifo clear");
    a_init_pulse: assert property (cw && cb == 8'h83 |-> ##[1:2] o_soft_init)
        else $error("no soft init");
    a_init_dflt: assert property (o_soft_init |-> ##[1:2] !o_pll_aux)
        else $error("init kept aux");
    a_len_force: assert property (cw && cb == 8'h98 |-> ##[1:3] o_rx_len_force && o_rx_len == 10'h010)
        else $error("bad rx length");
    c_tx: cover property (o_tx_start);
    c_hold: cover property (o_rx_hold);
    c_init: cover property (o_soft_init);
endmodule
bind rdc_top rdc_top_checker i_chk (.*);

/* dv/rdc_far_model.sv */
/* Transmitter stand-in: answers each start with a done pulse.
   Assumes a one-cycle start pulse from the command unit. */
`timescale 1ns/1ps
module rdc_far_model (
    input wire logic i_clock, i_rst_n, i_tx_start,
    output logic o_tx_done
);
    logic [3:0] cnt;
    // Frame lasts eight cycles so the hold release is seen late
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= 4'h0;
            o_tx_done <= 1'b0;
        end else begin
            o_tx_done <= (cnt == 4'h1);
            cnt <= i_tx_start ? 4'h8 : cnt - 4'(cnt != 4'h0);
        end
    end
endmodule

/* dv/tb_reader_direct_command_unit.sv */
/* Bench: APB command writes, output and readback checks.
   Assumes the checker is bound into the design. */
`timescale 1ns/1ps
module tb_reader_direct_command_unit;
    import rdc_pkg::*;
    logic i_clock = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic i_rx_end = 0, o_pready, o_pslverr, o_pll_aux, o_tx_start, o_rx_header;
    logic o_rx_nocrc, o_rx_len_force, o_rx_hold, o_soft_init, tx_done, err;
    logic [7:0] i_paddr = 8'h00, pin = 8'h00;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
    logic [1:0] o_tx_crc, crc_q;
    logic [9:0] o_rx_len;
    logic [7:0] cmds [4] = '{8'h90, 8'h92, 8'h91, 8'h98};
    logic [1:0] crcs [4] = '{RDC_CRC_16, RDC_CRC_NONE, RDC_CRC_16, RDC_CRC_5};
    int n_mismatch = 0, tests_run = 0, cyc = 0, n_start = 0;
    rdc_top i_dut (.i_mix_i(8'h00), .i_mix_q(8'h00), .i_adc_test(8'h00),
        .i_rx_rn16_vld(1'b0), .i_rx_rn16(16'h0), .i_adc_pin(pin), .i_tx_done(tx_done),
        .o_tx_ack_rn16(), .o_tx_rn16(), .o_fifo_clear(), .*);
    rdc_far_model i_far (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_tx_start(o_tx_start), .o_tx_done(tx_done));
    initial forever #5 i_clock = ~i_clock;
    // Start monitor and hang guard
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (o_tx_start === 1'b1) begin
            n_start <= n_start + 1;
            crc_q <= o_tx_crc;
        end
        if (cyc == 3000) begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish;
        end
    end
    // Full APB transfer; data and error taken at the ready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
        @(posedge i_clock);
        i_penable <= 1'b1;
        do @(posedge i_clock); while (o_pready !== 1'b1);
        {rd, err} = {o_prdata, o_pslverr};
        {i_psel, i_penable} <= 2'b00;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(posedge i_clock);
        chk(o_pll_aux, 0);
        apb(1, RDC_A_CMD, 32'h85);
        apb(1, RDC_A_CMD, 32'h04); // bit 7 clear: not a command
        apb(1, RDC_A_CMD, 32'h95);
        apb(1, RDC_A_CMD, 32'h80);
        repeat (3) @(posedge i_clock);
        chk(o_pll_aux, 1);
        chk(n_start, 0);
        apb(1, RDC_A_CMD, 32'h84);
        apb(0, 8'h3c, 32'h0);
        chk(err, 1);
        chk(o_pll_aux, 0);
        // Pin source then a mixer source
        pin <= 8'h5a;
        for (int k = 0; k < 2; k++) begin
            apb(1, RDC_A_CFG, k ? 32'h1 : 32'h3);
            apb(1, RDC_A_CMD, 32'h87);
            repeat (60) @(posedge i_clock);
            apb(0, RDC_A_ADC, 32'h0);
            chk(rd[8:0], k ? 9'h000 : 9'h05a);
        end
        apb(1, RDC_A_CMD, 32'h96);
        chk(o_rx_hold, 1);
        apb(1, RDC_A_CMD, 32'h97);
        chk(o_rx_hold, 0);
        // Each frame sent with the receiver blocked beforehand
        for (int k = 0; k < 4; k++) begin
            apb(1, RDC_A_CMD, 32'h96);
            // Code 91 goes ahead of its lengths, with a one-byte message
            if (k == 2)
                apb(1, RDC_A_CMD, {24'h0, cmds[k]});
            apb(1, RDC_A_TXLEN, k == 2 ? 32'h1 : 32'h3);
            if (k != 2)
                apb(1, RDC_A_CMD, {24'h0, cmds[k]});
            for (int b = 0; b < (k == 2 ? 1 : 3) && k < 3; b++) begin
                repeat (3) @(posedge i_clock);
                chk(n_start, k);
                apb(1, RDC_A_FIFO, 32'haa + b);
            end
            repeat (4) @(posedge i_clock);
            chk(n_start, k + 1);
            chk(crc_q, crcs[k]);
            chk(o_rx_header, k == 2);
            repeat (12) @(posedge i_clock);
            chk(o_rx_hold, 0);
        end
        chk(o_rx_nocrc, 1);
        // Delayed frame: wait runs from reception end, receive wait follows it
        apb(1, RDC_A_TXDLY, 32'h2);
        apb(1, RDC_A_RXDLY, 32'h1);
        i_rx_end <= 1'b1;
        @(posedge i_clock);
        i_rx_end <= 1'b0;
        apb(1, RDC_A_CMD, 32'h93);
        apb(1, RDC_A_TXLEN, 32'h3);
        for (int b = 0; b < 3; b++)
            apb(1, RDC_A_FIFO, 32'h10 + b);
        repeat (160) @(posedge i_clock);
        chk(n_start, 4);
        repeat (40) @(posedge i_clock);
        chk(n_start, 5);
        chk(crc_q, RDC_CRC_NONE);
        chk(o_rx_hold, 1);
        repeat (100) @(posedge i_clock);
        chk(o_rx_hold, 0);
        apb(1, RDC_A_CMD, 32'h8f);
        apb(1, RDC_A_CMD, 32'h85);
        apb(1, RDC_A_CMD, 32'h83);
        repeat (3) @(posedge i_clock);
        chk(o_pll_aux, 0);
        tally_and_finish;
    end
endmodule
